// ### hw/wptx_phase_ctrl.sv
/*
  wptx_phase_ctrl: phase controller of a wireless power transmitter. Walks through
  selection, ping, identification/configuration and power transfer, drives the
  operating point, coil selection and status indicators.
  Assumes packets, start-bit strobes and thermistor samples arrive on mclk from
  same-clock logic; coil_resp comes from an analog comparator and is synchronised.
*/
// Functional notes
// RULE1: receiver sends signal strength in time
// RULE2: no start bit: remove power after delay
// RULE3: signal strength packet advances to id/config
// RULE4: identification first, configuration last
// RULE5: extended identification only when flag set
// RULE6: fixed 175 kHz, 50% during id/config
// RULE7: at most seven optional packets before configuration
// RULE8: good config enters transfer, else selection
// RULE9: control error packets adjust delivered power
// RULE10: transfer accepts listed packet kinds
// RULE11: bad sequence or deadline: back to selection
// RULE12: sample thermistor; overheat stops power, error
// RULE13: stay in over-temperature until cooled
// RULE14: excessive power loss stops transfer, error
// RULE15: pull-down keeps threshold; pull-up disables detection
// RULE16: middle voltage offsets allowed loss proportionally
// RULE17: selection pulses coils, keeps responding one
// RULE18: transfer frequency kept within 110-205 kHz
// RULE19: end power packet returns to selection
module wptx_phase_ctrl #(
  parameter int unsigned SEL_INTERVAL_CYC = wptx_pkg::SEL_INTERVAL_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned PING_START_CYC = wptx_pkg::PING_START_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned PING_REMOVE_CYC = wptx_pkg::PING_REMOVE_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned PING_PKT_CYC = wptx_pkg::PING_PKT_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned ID_GAP_CYC = wptx_pkg::ID_GAP_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned PT_CE_CYC = wptx_pkg::PT_CE_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned PT_RP_CYC = wptx_pkg::PT_RP_MS * wptx_pkg::CYC_PER_MS,
  parameter int unsigned THERM_CYC = wptx_pkg::THERM_MS * wptx_pkg::CYC_PER_MS,
  parameter logic [11:0] THERM_LIMIT = 12'hC00 // thermistor code above which it is too hot
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire wptx_pkg::wptx_pkt_t pkt, // decoded packet strobe
  input wire logic hdr_start, // start bit of a header byte seen
  input wire logic coil_resp, // analog ping response, asynchronous
  input wire logic therm_valid, // thermistor sample ready
  input wire logic [11:0] therm_code, // thermistor sample, higher is hotter
  input wire logic [15:0] tx_mw, // transmitted power estimate
  input wire logic [11:0] fod_mv, // voltage on fod_offset_input
  output wptx_pkg::wptx_opp_t opp, // inverter operating point
  output logic [2:0] coil_sel, // one-hot coil enable
  output logic therm_req, // one-cycle request for a thermistor sample
  output logic led_ok, // charging indicator
  output logic led_err, // error indicator
  output wptx_pkg::wptx_phase_t phase // current phase
);
  wptx_pkg::wptx_phase_t next_phase; // phase for the next edge
  logic [31:0] tmr; // phase timer, restarts on every phase change
  logic [31:0] ce_tmr; // cycles since last control error packet
  logic [31:0] rp_tmr; // cycles since last received power packet
  logic [31:0] th_tmr; // thermistor sampling interval
  logic [1:0] coil_idx; // coil being probed or kept
  logic resp_meta; // synchroniser first stage
  logic resp_sync; // synchronised coil response
  logic start_seen; // header start bit seen in ping
  logic [1:0] id_step; // 0 wait id, 1 wait ext id, 2 options/config
  logic [2:0] opt_cnt; // optional packets seen
  logic hot; // latched over-temperature
  logic fod_fault; // loss check pulse
  logic pkt_opt; // header is optional in id/config
  logic pkt_xfer_ok; // header is allowed in transfer
  logic signed [9:0] freq_new; // frequency after control error step

  // header classes: known mandatory headers out of place are violations
  always_comb begin
    pkt_xfer_ok = !(pkt.header inside {wptx_pkg::HDR_SIG_STRENGTH, wptx_pkg::HDR_IDENT,
                                       wptx_pkg::HDR_EXT_IDENT, wptx_pkg::HDR_CONFIG}); // RULE10
    pkt_opt = pkt_xfer_ok && !(pkt.header inside {wptx_pkg::HDR_END_POWER, wptx_pkg::HDR_CTRL_ERR,
                                                 wptx_pkg::HDR_RECT_POWER, wptx_pkg::HDR_CHG_STATUS}); // RULE7
  end

  // control error raises power by lowering frequency; step is error/8
  always_comb begin
    freq_new = $signed({2'b00, opp.freq_khz}) - 10'($signed(pkt.data[7:0]) >>> 3); // RULE9
  end

  // two flops on the comparator; only the second is looked at
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      resp_meta <= 1'b0;
      resp_sync <= 1'b0;
    end else begin
      resp_meta <= coil_resp;
      resp_sync <= resp_meta;
    end
  end

  // phase sequencing
  always_comb begin
    next_phase = phase;
    if (hot) begin
      next_phase = wptx_pkg::WPTX_OTEMP; // RULE12
    end else begin
      unique case (phase)
        wptx_pkg::WPTX_SEL: begin
          if (tmr < 32'(wptx_pkg::SEL_PULSE_CYC) && resp_sync) next_phase = wptx_pkg::WPTX_PING; // RULE17
        end
        wptx_pkg::WPTX_PING: begin
          if (pkt.valid && pkt.header == wptx_pkg::HDR_SIG_STRENGTH) begin
            next_phase = wptx_pkg::WPTX_IDCFG; // RULE3
          end else if (!start_seen && tmr >= 32'(PING_START_CYC + PING_REMOVE_CYC) - 32'h1) begin
            next_phase = wptx_pkg::WPTX_SEL; // RULE2
          end else if (tmr >= 32'(PING_PKT_CYC) - 32'h1) begin
            next_phase = wptx_pkg::WPTX_SEL; // RULE1
          end
        end
        wptx_pkg::WPTX_IDCFG: begin
          if (pkt.valid) begin
            unique case (id_step)
              2'd0: if (pkt.header != wptx_pkg::HDR_IDENT) next_phase = wptx_pkg::WPTX_SEL; // RULE4
              2'd1: if (pkt.header != wptx_pkg::HDR_EXT_IDENT) next_phase = wptx_pkg::WPTX_SEL; // RULE5
              default: begin
                if (pkt.header == wptx_pkg::HDR_CONFIG) next_phase = wptx_pkg::WPTX_XFER; // RULE8
                else if (!pkt_opt || opt_cnt == wptx_pkg::MAX_OPTIONAL) next_phase = wptx_pkg::WPTX_SEL; // RULE7
              end
            endcase
          end else if (tmr >= 32'(ID_GAP_CYC) - 32'h1) begin
            next_phase = wptx_pkg::WPTX_SEL; // RULE8
          end
        end
        wptx_pkg::WPTX_XFER: begin
          if (fod_fault) next_phase = wptx_pkg::WPTX_SEL; // RULE14
          else if (pkt.valid && !pkt_xfer_ok) next_phase = wptx_pkg::WPTX_SEL; // RULE11
          else if (pkt.valid && pkt.header == wptx_pkg::HDR_END_POWER) next_phase = wptx_pkg::WPTX_SEL; // RULE19
          else if (ce_tmr >= 32'(PT_CE_CYC) - 32'h1 || rp_tmr >= 32'(PT_RP_CYC) - 32'h1) begin
            next_phase = wptx_pkg::WPTX_SEL; // RULE11
          end
        end
        wptx_pkg::WPTX_OTEMP: next_phase = wptx_pkg::WPTX_SEL; // RULE13
      endcase
    end
  end

  // phase register and phase timer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase <= wptx_pkg::WPTX_SEL;
      tmr <= 32'h0;
    end else begin
      phase <= next_phase;
      if (next_phase != phase) tmr <= 32'h0;
      else if (phase == wptx_pkg::WPTX_IDCFG && pkt.valid) tmr <= 32'h0; // gap runs per packet
      else if (phase == wptx_pkg::WPTX_SEL && tmr >= 32'(SEL_INTERVAL_CYC) - 32'h1) tmr <= 32'h0;
      else tmr <= tmr + 32'h1;
    end
  end

  // coil scan: next coil each sweep gap, kept once a response is found
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      coil_idx <= 2'd0;
    end else if (phase == wptx_pkg::WPTX_SEL && next_phase == wptx_pkg::WPTX_SEL
                 && tmr >= 32'(SEL_INTERVAL_CYC) - 32'h1) begin
      coil_idx <= (coil_idx == 2'd2) ? 2'd0 : coil_idx + 2'd1; // RULE17
    end
  end

  // coil enables: pulse in selection, held selected in ping, id/config and transfer, all off in over-temperature
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      coil_sel <= 3'h0;
    end else if (next_phase == wptx_pkg::WPTX_OTEMP) begin
      coil_sel <= 3'h0;
    end else if (next_phase != wptx_pkg::WPTX_SEL || tmr < 32'(wptx_pkg::SEL_PULSE_CYC) - 32'h1) begin
      coil_sel <= 3'(3'h1 << coil_idx); // RULE17
    end else begin
      coil_sel <= 3'h0;
    end
  end

  // ping start-bit tracking
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      start_seen <= 1'b0;
    end else if (phase != wptx_pkg::WPTX_PING) begin
      start_seen <= 1'b0;
    end else if (hdr_start && tmr < 32'(PING_START_CYC)) begin
      start_seen <= 1'b1; // RULE2
    end
  end

  // identification progress and optional packet count
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      id_step <= 2'd0;
      opt_cnt <= 3'h0;
    end else if (phase != wptx_pkg::WPTX_IDCFG) begin
      id_step <= 2'd0;
      opt_cnt <= 3'h0;
    end else if (pkt.valid) begin
      if (id_step == 2'd0) begin
        id_step <= pkt.data[wptx_pkg::ID_EXT_BIT] ? 2'd1 : 2'd2; // RULE5
      end else if (id_step == 2'd1) begin
        id_step <= 2'd2; // RULE4
      end else if (opt_cnt != wptx_pkg::MAX_OPTIONAL) begin
        opt_cnt <= opt_cnt + 3'h1; // RULE7
      end
    end
  end

  // transfer deadlines, restarted by their own packet kinds
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ce_tmr <= 32'h0;
      rp_tmr <= 32'h0;
    end else if (phase != wptx_pkg::WPTX_XFER) begin
      ce_tmr <= 32'h0;
      rp_tmr <= 32'h0;
    end else begin
      ce_tmr <= (pkt.valid && pkt.header == wptx_pkg::HDR_CTRL_ERR) ? 32'h0 : ce_tmr + 32'h1; // RULE11
      rp_tmr <= (pkt.valid && pkt.header == wptx_pkg::HDR_RECT_POWER) ? 32'h0 : rp_tmr + 32'h1; // RULE11
    end
  end

  // operating point: fixed until transfer, then steered and clamped
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      opp <= '{power_on: 1'b0, freq_khz: wptx_pkg::PING_FREQ_KHZ, duty_pct: wptx_pkg::FIXED_DUTY_PCT};
    end else begin
      opp.duty_pct <= wptx_pkg::FIXED_DUTY_PCT;
      opp.power_on <= next_phase inside {wptx_pkg::WPTX_PING, wptx_pkg::WPTX_IDCFG, wptx_pkg::WPTX_XFER}; // RULE12
      if (phase != wptx_pkg::WPTX_XFER) begin
        opp.freq_khz <= wptx_pkg::PING_FREQ_KHZ; // RULE6
      end else if (pkt.valid && pkt.header == wptx_pkg::HDR_CTRL_ERR) begin
        if (freq_new < $signed({2'b00, wptx_pkg::FREQ_MIN_KHZ})) opp.freq_khz <= wptx_pkg::FREQ_MIN_KHZ; // RULE18
        else if (freq_new > $signed({2'b00, wptx_pkg::FREQ_MAX_KHZ})) opp.freq_khz <= wptx_pkg::FREQ_MAX_KHZ; // RULE18
        else opp.freq_khz <= freq_new[7:0]; // RULE9
      end
    end
  end

  // thermistor sampling in every phase; hot held until a cool sample
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      th_tmr <= 32'h0;
      therm_req <= 1'b0;
      hot <= 1'b0;
    end else begin
      therm_req <= th_tmr == 32'(THERM_CYC) - 32'h1; // RULE12
      th_tmr <= (th_tmr == 32'(THERM_CYC) - 32'h1) ? 32'h0 : th_tmr + 32'h1;
      if (therm_valid) hot <= therm_code > THERM_LIMIT; // RULE13
    end
  end

  // indicators: error on heat or loss, cleared by the next good transfer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      led_err <= 1'b0;
      led_ok <= 1'b0;
    end else begin
      led_ok <= next_phase == wptx_pkg::WPTX_XFER;
      if (hot || fod_fault) led_err <= 1'b1; // RULE12
      else if (phase == wptx_pkg::WPTX_IDCFG && next_phase == wptx_pkg::WPTX_XFER) led_err <= 1'b0;
    end
  end

  // loss check on each received power report during transfer
  wptx_fod_check u_fod (
    .mclk(mclk),
    .rst_b(rst_b),
    .check(phase == wptx_pkg::WPTX_XFER && pkt.valid && pkt.header == wptx_pkg::HDR_RECT_POWER),
    .tx_mw(tx_mw),
    .rx_mw(pkt.data),
    .fod_mv(fod_mv),
    .fod_fault(fod_fault)
  );
endmodule : wptx_phase_ctrl

// ### hw/wptx_pkg.sv
/*
  wptx_pkg: shared constants and carrier types for the wireless power transmitter
  phase controller. Assumes a single 50 MHz clock and packets already recovered
  and checked by a demodulator running on that same clock.
*/
package wptx_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 50_000_000;

  // packet headers
  localparam logic [7:0] HDR_SIG_STRENGTH = 8'h01; // signal strength
  localparam logic [7:0] HDR_END_POWER = 8'h02; // end power transfer
  localparam logic [7:0] HDR_CTRL_ERR = 8'h03; // control error
  localparam logic [7:0] HDR_RECT_POWER = 8'h04; // rectified / received power
  localparam logic [7:0] HDR_CHG_STATUS = 8'h05; // charge status
  localparam logic [7:0] HDR_HOLDOFF = 8'h06; // power control hold-off
  localparam logic [7:0] HDR_PROP_LO = 8'h18; // lowest proprietary header
  localparam logic [7:0] HDR_PROP_HI = 8'hF2; // highest proprietary header
  localparam logic [7:0] HDR_CONFIG = 8'h51; // configuration
  localparam logic [7:0] HDR_IDENT = 8'h71; // identification
  localparam logic [7:0] HDR_EXT_IDENT = 8'h81; // extended identification

  // field positions
  localparam int unsigned ID_EXT_BIT = 7; // extension flag within identification data

  // id and config limits
  localparam logic [2:0] MAX_OPTIONAL = 3'h7; // optional packets allowed before configuration

  // operating point
  localparam logic [7:0] PING_FREQ_KHZ = 8'hAF; // 175 kHz during ping and id/config
  localparam logic [6:0] FIXED_DUTY_PCT = 7'h32; // 50 % duty
  localparam logic [7:0] FREQ_MIN_KHZ = 8'h6E; // 110 kHz
  localparam logic [7:0] FREQ_MAX_KHZ = 8'hCD; // 205 kHz

  // foreign object adjustment input, in millivolts
  localparam logic [11:0] FOD_MV_LO = 12'h032; // 50 mV, pull-down only below this
  localparam logic [11:0] FOD_MV_ZERO = 12'h4B0; // 1200 mV, zero offset
  localparam logic [11:0] FOD_MV_HI = 12'h92E; // 2350 mV, pull-up only 50 mV above this
  localparam logic [9:0] FOD_OFS_SCALE = 10'h10B; // 267/1024 ~ 300 mW over 1150 mV
  localparam logic [15:0] FOD_LIMIT_MW = 16'h01F4; // built-in allowed loss, 500 mW

  // timing, in their own units, with derived cycle counts
  localparam int unsigned SEL_PULSE_US = 70; // analog ping length per coil
  localparam int unsigned SEL_PULSE_CYC = SEL_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SEL_INTERVAL_MS = 500; // gap between coil sweeps
  localparam int unsigned PING_START_MS = 20; // wait for header start bit
  localparam int unsigned PING_REMOVE_MS = 5; // delay before power removal
  localparam int unsigned PING_PKT_MS = 65; // signal strength deadline
  localparam int unsigned ID_GAP_MS = 25; // longest gap between id/config packets
  localparam int unsigned PT_CE_MS = 1800; // control error deadline
  localparam int unsigned PT_RP_MS = 23000; // rectified power deadline
  localparam int unsigned THERM_MS = 10; // thermistor sample interval
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // phases, gray coded along selection, ping, id/config, transfer
  typedef enum logic [2:0] {
    WPTX_SEL = 3'b000,
    WPTX_PING = 3'b001,
    WPTX_IDCFG = 3'b011,
    WPTX_XFER = 3'b010,
    WPTX_OTEMP = 3'b110
  } wptx_phase_t;

  // decoded packet from the demodulator
  typedef struct packed {
    logic valid; // one-cycle strobe
    logic [7:0] header; // packet header
    logic [15:0] data; // first two message bytes, byte 0 low
  } wptx_pkt_t;

  // inverter operating point
  typedef struct packed {
    logic power_on; // power signal applied
    logic [7:0] freq_khz; // switching frequency
    logic [6:0] duty_pct; // duty cycle
  } wptx_opp_t;
endpackage : wptx_pkg

// ### hw/wptx_fod_check.sv
/*
  wptx_fod_check: foreign object loss check. Compares transmitted power with the
  received power reported by the receiver, against a built-in limit shifted by
  the adjustment voltage. Assumes fod_mv is a settled, same-clock digitised value.
*/
module wptx_fod_check (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic check, // one-cycle strobe: new received power report
  input wire logic [15:0] tx_mw, // transmitted power estimate
  input wire logic [15:0] rx_mw, // received power report
  input wire logic [11:0] fod_mv, // voltage on fod_offset_input
  output logic fod_fault // one-cycle pulse: loss too large
);
  logic signed [17:0] ofs_mv; // adjustment voltage relative to 1.20 V
  logic signed [28:0] ofs_prod; // scaled offset before the shift
  logic signed [17:0] allow_mw; // allowed loss after adjustment
  logic signed [17:0] loss_mw; // measured loss
  logic [11:0] clip_mv; // voltage clamped to the proportional range
  logic fod_off; // pull-up only: detection disabled

  // clamp, then offset proportional to voltage, ~300 mW at either end
  always_comb begin
    fod_off = fod_mv > wptx_pkg::FOD_MV_HI + 12'h032; // RULE15
    clip_mv = (fod_mv > wptx_pkg::FOD_MV_HI) ? wptx_pkg::FOD_MV_HI : fod_mv;
    ofs_mv = $signed({6'h00, clip_mv}) - $signed({6'h00, wptx_pkg::FOD_MV_ZERO});
    ofs_prod = ofs_mv * $signed({1'b0, wptx_pkg::FOD_OFS_SCALE}); // RULE16
    if (fod_mv < wptx_pkg::FOD_MV_LO) begin
      allow_mw = $signed({2'h0, wptx_pkg::FOD_LIMIT_MW}); // RULE15
    end else begin
      allow_mw = $signed({2'h0, wptx_pkg::FOD_LIMIT_MW}) + 18'(ofs_prod >>> 10); // RULE16
    end
    loss_mw = $signed({2'h0, tx_mw}) - $signed({2'h0, rx_mw});
  end

  // a check only counts on a fresh report, so stale figures never trip it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fod_fault <= 1'b0;
    end else begin
      fod_fault <= check && !fod_off && (loss_mw > allow_mw); // RULE14
    end
  end
endmodule : wptx_fod_check

// ### dv/wptx_phase_ctrl_asserts.sv
/*
  wptx_phase_ctrl_asserts: port-level checks of the phase controller.
  Assumes it is bound to wptx_phase_ctrl: one clock, synchronous active-low reset.
*/
module wptx_phase_ctrl_asserts #(
  parameter logic [11:0] THERM_LIMIT = 12'hC00 // code above this is too hot
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire wptx_pkg::wptx_pkt_t pkt,
  input wire logic therm_valid,
  input wire logic [11:0] therm_code,
  input wire wptx_pkg::wptx_opp_t opp,
  input wire logic [2:0] coil_sel,
  input wire logic led_ok,
  input wire logic led_err,
  input wire wptx_pkg::wptx_phase_t phase
);
  timeunit 1ns;
  timeprecision 100ps;
  // a hot sample outranks any packet taken in the following cycle
  logic hot;
  assign hot = therm_valid && (therm_code > THERM_LIMIT);
  // one clock domain
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  ping_adv_a: assert property (
    phase == wptx_pkg::WPTX_PING && pkt.valid && pkt.header == wptx_pkg::HDR_SIG_STRENGTH && !hot
    |=> phase == wptx_pkg::WPTX_IDCFG) else $error("ping did not advance");
  idcfg_fixed_a: assert property (
    phase == wptx_pkg::WPTX_IDCFG |-> opp.freq_khz == wptx_pkg::PING_FREQ_KHZ
    && opp.duty_pct == wptx_pkg::FIXED_DUTY_PCT) else $error("operating point moved in id/config");
  xfer_ind_a: assert property (
    led_ok == (phase == wptx_pkg::WPTX_XFER) && (phase != wptx_pkg::WPTX_XFER || opp.power_on))
    else $error("transfer indicator or power wrong");
  freq_range_a: assert property (
    phase == wptx_pkg::WPTX_XFER |-> opp.freq_khz >= wptx_pkg::FREQ_MIN_KHZ
    && opp.freq_khz <= wptx_pkg::FREQ_MAX_KHZ) else $error("frequency out of range");
  hot_stop_a: assert property (
    hot |-> ##2 phase == wptx_pkg::WPTX_OTEMP && !opp.power_on && led_err && coil_sel == 3'h0)
    else $error("overheat did not stop power");
  otemp_hold_a: assert property (
    phase == wptx_pkg::WPTX_OTEMP && !($past(therm_valid) && $past(therm_code) <= THERM_LIMIT)
    |=> $stable(phase)) else $error("left overheat while hot");
  end_pwr_a: assert property (
    phase == wptx_pkg::WPTX_XFER && pkt.valid && pkt.header == wptx_pkg::HDR_END_POWER && !hot
    |=> phase == wptx_pkg::WPTX_SEL && !opp.power_on) else $error("end power ignored");
  xfer_bad_a: assert property (
    phase == wptx_pkg::WPTX_XFER && pkt.valid && pkt.header == wptx_pkg::HDR_IDENT && !hot
    |=> phase == wptx_pkg::WPTX_SEL) else $error("bad transfer packet ignored");
endmodule : wptx_phase_ctrl_asserts

bind wptx_phase_ctrl wptx_phase_ctrl_asserts #(.THERM_LIMIT(THERM_LIMIT)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .pkt(pkt), .therm_valid(therm_valid), .therm_code(therm_code), .opp(opp), .coil_sel(coil_sel),
  .led_ok(led_ok), .led_err(led_err), .phase(phase));

// ### dv/wptx_rx_model.sv
/*
  wptx_rx_model: behavioural mobile receiver, as seen after the demodulator.
  Assumes the caller paces packets; gap lets it answer slowly.
*/
module wptx_rx_model (
  input wire logic mclk,
  output wptx_pkg::wptx_pkt_t pkt,
  output logic hdr_start
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: header and data scrambled so stale values are never trusted
  initial begin
    pkt = '{valid: 1'b0, header: 8'hFF, data: 16'hFFFF};
    hdr_start = 1'b0;
  end
  // one packet: start bit one cycle ahead of the decoded strobe
  task automatic send(input logic [7:0] hdr, input logic [15:0] dat, input int gap);
    repeat (gap + 1) @(posedge mclk);
    hdr_start <= 1'b1;
    @(posedge mclk);
    hdr_start <= 1'b0;
    pkt <= '{valid: 1'b1, header: hdr, data: dat};
    @(posedge mclk);
    pkt <= '{valid: 1'b0, header: ~hdr, data: ~dat};
    #1;
  endtask : send
endmodule : wptx_rx_model

// ### dv/wptx_phase_ctrl_tb.sv
/*
  wptx_phase_ctrl_tb: self-checking bench for the phase controller.
  Assumes shortened timing parameters and the receiver model beside it.
*/
module wptx_phase_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0; // 50 MHz
  logic rst_b = 1'b0;
  logic coil_resp = 1'b0;
  logic therm_valid = 1'b0;
  logic [11:0] therm_code = 12'h000;
  logic [15:0] tx_mw = 16'h03E8; // 1000 mW sent
  logic [11:0] fod_mv = 12'h000;
  logic hot = 1'b0; // thermistor above limit
  logic hdr_start;
  logic therm_req;
  logic led_ok;
  logic led_err;
  logic [2:0] coil_sel;
  wptx_pkg::wptx_pkt_t pkt;
  wptx_pkg::wptx_opp_t opp;
  wptx_pkg::wptx_phase_t phase;
  wptx_pkg::wptx_phase_t last_ph = wptx_pkg::WPTX_SEL;
  wptx_pkg::wptx_phase_t exp_q[$]; // phase changes still to come
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int f; // model of switching frequency
  logic [7:0] ce;
  logic [15:0] d;
  // adjust voltage vs received power: pull-down, pull-up, top of range; none may fault
  logic [11:0] mv_t[3] = '{12'h000, 12'h9C4, 12'h92E};
  logic [15:0] rx_t[3] = '{16'h0258, 16'h0000, 16'h012C};

  always #10 mclk = ~mclk;

  wptx_phase_ctrl #(.SEL_INTERVAL_CYC(8000), .PING_START_CYC(200), .PING_REMOVE_CYC(100), .PT_CE_CYC(800),
    .THERM_CYC(300)) u_dut (.mclk(mclk), .rst_b(rst_b),
    .pkt(pkt), .hdr_start(hdr_start), .coil_resp(coil_resp), .therm_valid(therm_valid), .therm_code(therm_code),
    .tx_mw(tx_mw), .fod_mv(fod_mv), .opp(opp), .coil_sel(coil_sel), .therm_req(therm_req), .led_ok(led_ok),
    .led_err(led_err), .phase(phase));
  wptx_rx_model u_rx (.mclk(mclk), .pkt(pkt), .hdr_start(hdr_start));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // wait, bounded, until every noted phase change has been seen
  task automatic drain(input int n);
    for (int i = 0; i < n && exp_q.size() > 0; i++) begin
      @(posedge mclk);
    end
    chk("pending_phase", exp_q.size(), 0);
    exp_q.delete();
    #1;
  endtask : drain

  // watcher: each phase change must match the oldest note; also the hang limit
  always @(posedge mclk) begin
    cyc++;
    if (rst_b && phase !== last_ph) begin
      chk("phase", phase, (exp_q.size() > 0) ? exp_q.pop_front() : last_ph);
    end
    last_ph = phase;
    if (cyc == 90000) begin
      n_fail++;
      give_verdict();
    end
  end

  // thermistor front end answers each request a cycle later; C00 sits on the limit
  always @(posedge mclk) begin
    therm_valid <= therm_req;
    therm_code <= hot ? 12'hC01 : 12'hC00;
  end

  // hold a coil response until the sweep finds it
  task automatic to_ping();
    exp_q.push_back(wptx_pkg::WPTX_PING);
    @(posedge mclk);
    coil_resp <= 1'b1;
    drain(9000);
    chk("coil_onehot", $countones(coil_sel), 1);
    @(posedge mclk);
    coil_resp <= 1'b0;
  endtask : to_ping

  // ping, identification, optionals, configuration; an eighth optional is refused
  task automatic go_xfer(input bit ext, input int nopt);
    logic [7:0] h;
    to_ping();
    exp_q.push_back(wptx_pkg::WPTX_IDCFG);
    u_rx.send(wptx_pkg::HDR_SIG_STRENGTH, 16'($urandom), 0);
    d = 16'($urandom);
    d[wptx_pkg::ID_EXT_BIT] = ext;
    u_rx.send(wptx_pkg::HDR_IDENT, d, $urandom_range(3));
    if (ext) begin
      u_rx.send(wptx_pkg::HDR_EXT_IDENT, 16'($urandom), 0);
    end
    for (int i = 0; i < nopt; i++) begin
      h = (i % 3 == 0) ? wptx_pkg::HDR_HOLDOFF : (i % 3 == 1) ? 8'h18 + 8'($urandom_range(218)) : 8'h10;
      if (h inside {wptx_pkg::HDR_CONFIG, wptx_pkg::HDR_IDENT, wptx_pkg::HDR_EXT_IDENT}) begin
        h = wptx_pkg::HDR_PROP_HI;
      end
      if (i == 7) begin
        exp_q.push_back(wptx_pkg::WPTX_SEL);
      end
      u_rx.send(h, 16'($urandom), 0);
      if (i < 7) begin
        chk("idcfg_opp", opp, {1'b1, wptx_pkg::PING_FREQ_KHZ, wptx_pkg::FIXED_DUTY_PCT});
      end
    end
    if (nopt < 8) begin
      exp_q.push_back(wptx_pkg::WPTX_XFER);
      u_rx.send(wptx_pkg::HDR_CONFIG, 16'($urandom), 0);
    end
    drain(5);
    chk("power_on", opp.power_on, nopt < 8);
    chk("led_ok", led_ok, nopt < 8);
  endtask : go_xfer

  // main sequence
  initial begin
    void'($urandom(32'h7E14));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk("reset_state", {phase, opp}, {wptx_pkg::WPTX_SEL, 1'b0, wptx_pkg::PING_FREQ_KHZ, wptx_pkg::FIXED_DUTY_PCT});
    go_xfer(1, 7);
    $display("test id_config done");
    f = 175;
    // full steps up pin the top, then steps down pin the bottom
    for (int i = 0; i < 14; i++) begin
      ce = (i < 3) ? 8'h80 : (i < 10) ? 8'h7F : 8'($urandom);
      f = f - ($signed(ce) >>> 3);
      f = (f > 205) ? 205 : (f < 110) ? 110 : f;
      u_rx.send(wptx_pkg::HDR_CTRL_ERR, {8'($urandom), ce}, 0);
      @(posedge mclk);
      #1;
      chk("ctrl_freq", opp.freq_khz, f[7:0]);
    end
    $display("test ctrl_error done");
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      fod_mv <= mv_t[i];
      u_rx.send(wptx_pkg::HDR_RECT_POWER, rx_t[i], 1);
      u_rx.send(wptx_pkg::HDR_CHG_STATUS, 16'($urandom), 0);
      chk("still_xfer", phase, wptx_pkg::WPTX_XFER);
    end
    exp_q.push_back(wptx_pkg::WPTX_SEL);
    u_rx.send(wptx_pkg::HDR_END_POWER, 16'($urandom), 0);
    drain(5);
    chk("end_power_off", opp.power_on, 1'b0);
    $display("test fod_adjust done");
    go_xfer(0, 2);
    exp_q.push_back(wptx_pkg::WPTX_SEL);
    // 2350 mV allows 799 mW; a loss of 800 mW is one too many
    u_rx.send(wptx_pkg::HDR_RECT_POWER, 16'h00C8, 0);
    drain(5);
    chk("fod_err_led", led_err, 1'b1);
    go_xfer(0, 8);
    $display("test fod_and_optionals done");
    go_xfer(0, 1);
    exp_q.push_back(wptx_pkg::WPTX_SEL);
    u_rx.send(wptx_pkg::HDR_IDENT, 16'($urandom), 0);
    drain(5);
    go_xfer(1, 0);
    exp_q.push_back(wptx_pkg::WPTX_SEL);
    drain(900);
    to_ping();
    exp_q.push_back(wptx_pkg::WPTX_SEL);
    drain(400);
    chk("ping_off", opp.power_on, 1'b0);
    $display("test timeouts done");
    go_xfer(0, 3);
    exp_q.push_back(wptx_pkg::WPTX_OTEMP);
    @(posedge mclk);
    hot <= 1'b1;
    drain(400);
    chk("otemp_out", {opp.power_on, coil_sel, led_err}, 5'b00001);
    // two more hot samples: the watcher flags any exit meanwhile
    repeat (700) @(posedge mclk);
    exp_q.push_back(wptx_pkg::WPTX_SEL);
    hot <= 1'b0;
    drain(400);
    $display("test over_temp done");
    give_verdict();
  end
endmodule : wptx_phase_ctrl_tb
